/* hw/pfcc_resolve.sv */
// Resolves the flow-control state in effect from manual and negotiated inputs.
`default_nettype none
module pfcc_resolve
  import pfcc_pkg::*;
(
  // Inputs
  input  wire pfcc_cfg_t  cfg_i,
  input  wire pfcc_link_t link_i,
  // Result
  output var  pfcc_cur_t  cur_o
);
  always_comb begin
    cur_o.current_duplex = link_i.half_duplex;
    if (link_i.half_duplex) begin
      // Pause frames exist only in full duplex.
      cur_o.current_rx_pause_enable = 1'b0;
      cur_o.current_tx_pause_enable = 1'b0;
    end else if (cfg_i.manual_pause_select || !link_i.an_enable) begin
      cur_o.current_rx_pause_enable = cfg_i.manual_rx_pause_enable;
      cur_o.current_tx_pause_enable = cfg_i.manual_tx_pause_enable;
    end else begin
      cur_o.current_rx_pause_enable = link_i.an_rx_pause;
      cur_o.current_tx_pause_enable = link_i.an_tx_pause;
    end
  end
endmodule
`default_nettype wire

/* hw/pfcc_top.sv */
// Port 1 flow-control configuration and status register.
`include "pfcc_consts.svh"
`default_nettype none
module pfcc_top
  import pfcc_pkg::*;
#(
  parameter int ADDR_W = `PFCC_ADDR_W
)(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // Host register bus
  input  wire logic              reg_cs_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  output var  logic [31:0]       reg_rdata_o,
  output var  logic              reg_rvalid_o,
  // Straps and EEPROM loader
  input  wire pfcc_strap_t       strap_i,
  input  wire logic              strap_reload_i,
  // Port PHY link state
  input  wire pfcc_link_t        link_i,
  // Port MAC controls
  output var  logic              mac_backpressure_en_o,
  output var  logic              mac_rx_pause_en_o,
  output var  logic              mac_tx_pause_en_o,
  output var  logic              mac_half_duplex_o
);
  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  pfcc_cfg_t cfg_ff;
  pfcc_cfg_t nxt_cfg;
  pfcc_cfg_t strap_cfg;
  pfcc_cfg_t wr_cfg;
  logic      rst_seen_ff;
  logic      nxt_rst_seen;
  logic      hit;
  logic      wr_hit;
  logic      strap_load;

  assign hit        = reg_cs_i && (reg_addr_i == ADDR_W'(`PFCC_FC_OFFSET));
  assign wr_hit     = hit && reg_wr_i;
  // The straps apply in the first cycle after release and on each
  // reload, so nothing reads them while reset is still held.
  assign strap_load = !rst_seen_ff || strap_reload_i;

  // Field values that a strap load gives. Both pause enables share the
  // full-duplex pause strap.
  always_comb begin
    strap_cfg.backpressure_enable =
      strap_i.backpressure_default_strap;
    strap_cfg.manual_rx_pause_enable =
      strap_i.full_duplex_pause_default_strap;
    strap_cfg.manual_tx_pause_enable =
      strap_i.full_duplex_pause_default_strap;
    strap_cfg.manual_pause_select =
      strap_i.manual_select_default_strap;
  end

  // Field values that a host write gives; bits 31 to 7 and 5 to 3 are dropped.
  always_comb begin
    wr_cfg.backpressure_enable    = reg_wdata_i[`PFCC_BIT_BP_EN];
    wr_cfg.manual_rx_pause_enable = reg_wdata_i[`PFCC_BIT_RX_EN];
    wr_cfg.manual_tx_pause_enable = reg_wdata_i[`PFCC_BIT_TX_EN];
    wr_cfg.manual_pause_select    = reg_wdata_i[`PFCC_BIT_MANUAL];
  end

  // Writes carry no path toward the PHY advertisement register. A
  // reload in the same cycle as a host write wins and the write is lost.
  always_comb begin
    nxt_cfg      = cfg_ff;
    nxt_rst_seen = 1'b1;
    if (strap_load) begin
      nxt_cfg = strap_cfg;
    end else if (wr_hit) begin
      nxt_cfg = wr_cfg;
    end
  end

  // Reset clears the fields; the straps then load one cycle after
  // release, which is when the defaults first become visible.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_ff      <= '0;
      rst_seen_ff <= 1'b0;
    end else begin
      cfg_ff      <= nxt_cfg;
      rst_seen_ff <= nxt_rst_seen;
    end
  end

  // ----------------------------------------------------------------
  // Resolution of state in effect
  // ----------------------------------------------------------------
  // The resolver is purely combinational. Its result is registered by
  // the MAC controls and by the read path, so both lag a link change
  // by one cycle.
  pfcc_cur_t cur;

  pfcc_resolve u_resolve (
    .cfg_i  (cfg_ff),
    .link_i (link_i),
    .cur_o  (cur)
  );

  // ----------------------------------------------------------------
  // Register view
  // ----------------------------------------------------------------
  // The word a read returns. Status bits are live: they show the state
  // in effect at the read edge, whichever source decided it. Bits 31
  // to 7 stay zero.
  logic [31:0] reg_view;

  always_comb begin
    reg_view                    = `PFCC_READ_ZERO;
    reg_view[`PFCC_BIT_BP_EN]   = cfg_ff.backpressure_enable;
    reg_view[`PFCC_BIT_CUR_DUP] = cur.current_duplex;
    reg_view[`PFCC_BIT_CUR_RX]  = cur.current_rx_pause_enable;
    reg_view[`PFCC_BIT_CUR_TX]  = cur.current_tx_pause_enable;
    reg_view[`PFCC_BIT_RX_EN]   = cfg_ff.manual_rx_pause_enable;
    reg_view[`PFCC_BIT_TX_EN]   = cfg_ff.manual_tx_pause_enable;
    reg_view[`PFCC_BIT_MANUAL]  = cfg_ff.manual_pause_select;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Every read is answered one cycle later. Only the mapped offset
  // returns the register view; any other address reads as zero.
  // Writes never raise the answer strobe.
  logic        rd_req;
  logic        rd_hit;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        rvalid_ff;
  logic        nxt_rvalid;

  assign rd_req = reg_cs_i && reg_rd_i;
  assign rd_hit = hit && reg_rd_i;

  always_comb begin
    nxt_rvalid = rd_req;
    nxt_rdata  = `PFCC_READ_ZERO;
    if (rd_hit) begin
      nxt_rdata = reg_view;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_ff  <= `PFCC_READ_ZERO;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // MAC controls
  // ----------------------------------------------------------------
  // Backpressure forces collisions, which only means something in half
  // duplex, so its enable is masked by the duplex in effect. All four
  // controls are registered and lag the link state by one cycle.
  logic bp_ff;
  logic nxt_bp;
  logic rxp_ff;
  logic nxt_rxp;
  logic txp_ff;
  logic nxt_txp;
  logic dup_ff;
  logic nxt_dup;

  always_comb begin
    nxt_bp  = cfg_ff.backpressure_enable && cur.current_duplex;
    nxt_rxp = cur.current_rx_pause_enable;
    nxt_txp = cur.current_tx_pause_enable;
    nxt_dup = cur.current_duplex;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bp_ff  <= 1'b0;
      rxp_ff <= 1'b0;
      txp_ff <= 1'b0;
      dup_ff <= 1'b0;
    end else begin
      bp_ff  <= nxt_bp;
      rxp_ff <= nxt_rxp;
      txp_ff <= nxt_txp;
      dup_ff <= nxt_dup;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o           = rdata_ff;
  assign reg_rvalid_o          = rvalid_ff;
  assign mac_backpressure_en_o = bp_ff;
  assign mac_rx_pause_en_o     = rxp_ff;
  assign mac_tx_pause_en_o     = txp_ff;
  assign mac_half_duplex_o     = dup_ff;
endmodule
`default_nettype wire

/* pkg/pfcc_consts.svh */
// Constants for the port 1 flow-control configuration register.
`ifndef PFCC_CONSTS_SVH
`define PFCC_CONSTS_SVH
`define PFCC_ADDR_W         12
`define PFCC_FC_OFFSET      12'h1A0
`define PFCC_BIT_MANUAL     0
`define PFCC_BIT_TX_EN      1
`define PFCC_BIT_RX_EN      2
`define PFCC_BIT_CUR_TX     3
`define PFCC_BIT_CUR_RX     4
`define PFCC_BIT_CUR_DUP    5
`define PFCC_BIT_BP_EN      6
`define PFCC_RESERVED_MSB   31
`define PFCC_RESERVED_LSB   7
`define PFCC_READ_ZERO      32'h0000_0000
`endif

/* pkg/pfcc_pkg.sv */
// Types shared by the port 1 flow-control configuration block.
`default_nettype none
package pfcc_pkg;
  // Writable fields of the register.
  typedef struct packed {
    logic backpressure_enable;
    logic manual_rx_pause_enable;
    logic manual_tx_pause_enable;
    logic manual_pause_select;
  } pfcc_cfg_t;

  // Link state reported by the port PHY.
  typedef struct packed {
    logic an_enable;
    logic half_duplex;
    logic an_rx_pause;
    logic an_tx_pause;
  } pfcc_link_t;

  // Straps, loaded at reset or rewritten by the EEPROM loader.
  typedef struct packed {
    logic backpressure_default_strap;
    logic full_duplex_pause_default_strap;
    logic manual_select_default_strap;
  } pfcc_strap_t;

  // Flow-control state in effect on the port.
  typedef struct packed {
    logic current_duplex;
    logic current_rx_pause_enable;
    logic current_tx_pause_enable;
  } pfcc_cur_t;
endpackage
`default_nettype wire

/* tb/pfcc_host.sv */
// Host CPU model that drives the register bus.
`default_nettype none
module pfcc_host (
  // Answer from the register
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        rvalid_i,
  // Request to the register
  output var  logic        cs_o,
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [11:0] addr_o,
  output var  logic [31:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cs_o, wr_o, rd_o, addr_o, wdata_o} = '0;
  // Holds a request over one edge; the read answer is taken just after it.
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [32:0] q);
    {cs_o, wr_o, rd_o, addr_o, wdata_o} = {1'b1, w, !w, a, d};
    @(posedge clk_i);
    #1;
    q = {rvalid_i, rdata_i};
  endtask
  // Released control lines drop to zero; address and data lines show the inverse of their last value.
  task automatic idle();
    {cs_o, wr_o, rd_o, addr_o, wdata_o} = {3'h0, ~addr_o, ~wdata_o};
  endtask
endmodule
`default_nettype wire

/* tb/pfcc_top_chk.sv */
// Port assertions for the flow-control register.
`include "pfcc_consts.svh"
`default_nettype none
module pfcc_top_chk
  import pfcc_pkg::*;
(
  // Watched ports
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        reg_cs_i,
  input wire logic        reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire pfcc_link_t  link_i,
  input wire logic        mac_backpressure_en_o,
  input wire logic        mac_rx_pause_en_o,
  input wire logic        mac_tx_pause_en_o,
  input wire logic        mac_half_duplex_o
);
  logic             hit_ff;
  pfcc_link_t       lk_ff;
  wire logic        rq = reg_cs_i && reg_rd_i;
  wire logic        hit = rq && reg_addr_i == `PFCC_FC_OFFSET;
  wire logic [31:0] d = reg_rdata_o;
  wire logic        f = reg_rvalid_o && hit_ff && !d[5];
  wire logic        m = f && (d[0] || !lk_ff.an_enable);
  always_ff @(posedge sys_clk_i) begin
    hit_ff <= hit;
    lk_ff  <= link_i;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_answer: assert property (rq |=> reg_rvalid_o)
    else $error("no answer");
  a_no_stray_answer: assert property (!rq |=> !reg_rvalid_o)
    else $error("stray answer");
  a_unmapped_zero: assert property (rq && !hit |=> d == 32'h0)
    else $error("unmapped data");
  a_reserved_zero: assert property (reg_rvalid_o |-> d[31:7] == 25'h0)
    else $error("reserved bits");
  a_duplex_lag: assert property ($past(rst_n_i) |->
    mac_half_duplex_o == $past(link_i.half_duplex)) else $error("duplex");
  a_half_no_pause: assert property (mac_half_duplex_o |->
    !mac_rx_pause_en_o && !mac_tx_pause_en_o) else $error("half pause");
  a_status_mirror: assert property (reg_rvalid_o && hit_ff |->
    d[5:3] == {mac_half_duplex_o, mac_rx_pause_en_o, mac_tx_pause_en_o} &&
    mac_backpressure_en_o == (d[6] && d[5])) else $error("mirror");
  a_manual_wins: assert property (m |-> d[4:3] == d[2:1])
    else $error("manual");
  a_neg_wins: assert property (f && !d[0] && lk_ff.an_enable |->
    d[4:3] == {lk_ff.an_rx_pause, lk_ff.an_tx_pause}) else $error("neg");
  c_manual: cover property (m);
  c_negotiated: cover property (f && !d[0] && lk_ff.an_enable);
  c_backpressure: cover property (mac_backpressure_en_o);
endmodule
bind pfcc_top pfcc_top_chk i_pfcc_top_chk (.*);
`default_nettype wire

/* tb/tb_pfcc_top.sv */
// Self-checking bench for the port 1 flow-control register.
`include "pfcc_consts.svh"
`default_nettype none
module tb_pfcc_top
  import pfcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, rl = 1'b0;
  logic        cs, wr, rd, rv, bp, rx, tx, hd;
  logic [11:0] ad, a;
  logic [31:0] wd, rdat, d;
  logic [32:0] q;
  pfcc_strap_t st;
  pfcc_link_t  lk;
  int          seed = 39, failures = 0, cmp_count = 0, m, e, i;
  always #5 sys_clk_i = ~sys_clk_i;
  pfcc_top i_pfcc_top (.sys_clk_i, .rst_n_i, .reg_cs_i(cs), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .strap_i(st), .strap_reload_i(rl), .link_i(lk),
    .mac_backpressure_en_o(bp), .mac_rx_pause_en_o(rx),
    .mac_tx_pause_en_o(tx), .mac_half_duplex_o(hd));
  pfcc_host i_pfcc_host (.clk_i(sys_clk_i), .rdata_i(rdat), .rvalid_i(rv),
    .cs_o(cs), .wr_o(wr), .rd_o(rd), .addr_o(ad), .wdata_o(wd));
  task automatic cmp(string n, logic [32:0] x, logic [32:0] g);
    cmp_count++;
    if (x !== g) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cmp_mac(logic [3:0] x, logic [3:0] g);
    cmp_count++;
    if (x !== g) begin
      failures++;
      $display("wrong value mac expected %h seen %h", x, g);
    end
  endtask
  // Half duplex clears pause; otherwise manual or negotiated enables apply.
  task automatic rdc();
    e = (m & 32'h47) | (lk[2] ? 32'h20 :
        (m[0] || !lk[3] ? m[2:1] : lk[1:0]) << 3);
    i_pfcc_host.acc(1'b0, `PFCC_FC_OFFSET, wd, q);
    cmp("word", {1'b1, 32'(e)}, q);
    cmp_mac({e[6] & e[5], e[5:3]}, {bp, hd, rx, tx});
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    st = 3'($random(seed));
    lk = 4'h0;
    repeat (3) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    @(posedge sys_clk_i);
    #1 m = 32'({st[2], 3'h0, st[1], st[1], st[0]});
    rdc();
    $display("test defaults done");
    for (i = 0; i < 60; i++) begin
      lk = 4'($random(seed));
      st = 3'($random(seed));
      a = $random(seed) & 1 ? `PFCC_FC_OFFSET : 12'($random(seed));
      d = $random(seed);
      i_pfcc_host.acc(1'b1, a, d, q);
      cmp("write", 33'h0, q);
      if (a == `PFCC_FC_OFFSET) m = d & 32'h47;
      rdc();
      i_pfcc_host.acc(1'b0, `PFCC_FC_OFFSET ^ 12'(1 << i % 12), d, q);
      cmp("unmapped", {1'b1, 32'h0}, q);
    end
    $display("test random done");
    st = 3'($random(seed));
    rl = 1'b1;
    i_pfcc_host.acc(1'b1, `PFCC_FC_OFFSET, ~d, q);
    rl = 1'b0;
    cmp("reload write", 33'h0, q);
    m = 32'({st[2], 3'h0, st[1], st[1], st[0]});
    rdc();
    i_pfcc_host.idle();
    $display("test reload done");
    end_sim();
  end
  // Watchdog allows about ten times the expected run.
  initial begin
    #20000;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
